//--- hw/rbs_top.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - While the external reset pin is low the release state and counter are initialised and the chip is held in reset; mode and pull-up bits keep their values.
// - When the reset pin rises the boot-source strap level is captured as the initial operating mode.
// - Internal reset is removed synchronously to clk only after a fixed number of cycles after release.
// - The reset-state output follows the internal reset at all times.
// - An internal power-on reset asserts at power-up, independent of the reset pin.
// - The reset bit of the pull-up disable register switches off the reset pin pull-up.
// - A high boot strap selects external boot only when flash is unsecured; low selects internal boot.
// - A high address-width strap enables four extra address lines, 20 in total.
// - The address-width strap takes effect only jointly with boot strap and flash security state.
// - Secured flash with an external boot request yields internal boot with both mode bits zero.
// - The secured-state bit is captured only at reset and ignores later security changes.
module rbs_top
   import rbs_pkg::*;
#(
   parameter int unsigned RELEASE_CYCLES = rbs_pkg::RBS_RELEASE_CYCLES
) (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst,
   // Pins
   input wire logic reset_pin_n,
   input wire logic boot_source_strap,
   input wire logic address_width_strap,
   // Flash security state (1 = unsecured)
   input wire logic flash_unsecured,
   // Register port
   input wire rbs_pkg::rbs_bus_t bus,
   output logic [15:0] rdata,
   // Outputs
   output logic reset_state_output,
   output logic reset_pullup_en,
   output logic boot_pullup_en,
   output logic awidth_pullup_en,
   output rbs_pkg::rbs_mode_t mode,
   output logic [4:0] ext_addr_lines
);
   import rbs_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic pin_s;
   logic boot_s;
   logic aw_s;
   rbs_sync2 u_sync_rst (.clk(clk), .rst(rst), .d(reset_pin_n), .q(pin_s));
   rbs_sync2 u_sync_boot (.clk(clk), .rst(rst), .d(boot_source_strap), .q(boot_s));
   rbs_sync2 u_sync_aw (.clk(clk), .rst(rst), .d(address_width_strap), .q(aw_s));

   // ----------------------------------------
   // Power-on reset and release sequencer
   // ----------------------------------------
   rbs_state_t state_q, state_d;
   logic [RBS_CNT_W-1:0] cnt_q, cnt_d;
   logic [RBS_POR_W-1:0] por_q, por_d;
   logic irst_q, irst_d;
   logic pin_prev_q, pin_prev_d;
   rbs_mode_t mode_q, mode_d;
   logic [15:0] pudr_q, pudr_d;
   logic [15:0] rdata_q, rdata_d;
   logic por_busy;
   logic rise;

   assign por_busy = (por_q != RBS_POR_W'(RBS_POR_CYCLES));
   assign rise = pin_s & ~pin_prev_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      por_d = por_q;
      irst_d = irst_q;
      pin_prev_d = pin_s;
      mode_d = mode_q;
      if (por_busy) begin
         por_d = por_q + RBS_POR_W'(1);
      end
      unique case (state_q)
         RBS_ST_HOLD: begin
            irst_d = 1'b1;
            cnt_d = '0;
            if (!por_busy && pin_s) begin
               state_d = RBS_ST_COUNT;
            end
         end
         RBS_ST_COUNT: begin
            irst_d = 1'b1;
            if (cnt_q == RBS_CNT_W'(RELEASE_CYCLES - 1)) begin
               state_d = RBS_ST_RUN;
               irst_d = 1'b0;
            end else begin
               cnt_d = cnt_q + RBS_CNT_W'(1);
            end
         end
         RBS_ST_RUN: begin
            irst_d = 1'b0;
         end
         default: begin
            state_d = RBS_ST_HOLD;
         end
      endcase
      if (rise || (state_q == RBS_ST_HOLD && !por_busy && pin_s)) begin
         mode_d.secured_state_bit = flash_unsecured;
         mode_d.boot_mode_bit = boot_s & flash_unsecured;
         mode_d.wide_addr = aw_s & boot_s & flash_unsecured;
      end
      if (!pin_s) begin
         state_d = RBS_ST_HOLD;
         irst_d = 1'b1;
         cnt_d = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= RBS_ST_HOLD;
         cnt_q <= '0;
         por_q <= '0;
         irst_q <= 1'b1;
         pin_prev_q <= 1'b1;
         mode_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         por_q <= por_d;
         irst_q <= irst_d;
         pin_prev_q <= pin_prev_d;
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Pull-up disables survive internal reset so boot code settings are not lost on pin reset
   always_comb begin
      pudr_d = pudr_q;
      rdata_d = 16'h0000;
      if (bus.wr && bus.addr == RBS_PUDR_ADDR) begin
         pudr_d = bus.wdata;
      end
      if (bus.rd) begin
         unique case (bus.addr)
            RBS_PUDR_ADDR: rdata_d = pudr_q;
            RBS_MODE_ADDR: rdata_d = {13'h0000, mode_q.wide_addr, mode_q.secured_state_bit, mode_q.boot_mode_bit};
            RBS_STAT_ADDR: rdata_d = {12'h000, 2'(state_q), por_busy, irst_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pudr_q <= RBS_PUDR_RST_VAL;
         rdata_q <= 16'h0000;
      end else begin
         pudr_q <= pudr_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic rso_q;
   logic rpu_q;
   logic bpu_q;
   logic apu_q;
   logic [4:0] lines_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rso_q <= 1'b1;
         rpu_q <= 1'b1;
         bpu_q <= 1'b1;
         apu_q <= 1'b1;
         lines_q <= 5'h10;
      end else begin
         rso_q <= irst_d;
         rpu_q <= ~pudr_d[RBS_PUD_RESET_POS];
         bpu_q <= ~pudr_d[RBS_PUD_BOOT_POS];
         apu_q <= ~pudr_d[RBS_PUD_AWIDTH_POS];
         lines_q <= mode_d.wide_addr ? 5'(RBS_ADDR_WIDE) : 5'(RBS_ADDR_NARROW);
      end
   end
   assign reset_state_output = rso_q;
   assign reset_pullup_en = rpu_q;
   assign boot_pullup_en = bpu_q;
   assign awidth_pullup_en = apu_q;
   assign ext_addr_lines = lines_q;
   assign mode = mode_q;
   assign rdata = rdata_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_pin_holds_reset: assert property (@(posedge clk) disable iff (rst) !pin_s |=> reset_state_output)
      else $error("reset output low while pin held");
   a_output_follows: assert property (@(posedge clk) disable iff (rst) reset_state_output == irst_q)
      else $error("reset output differs from internal reset");
   a_release_delay: assert property (@(posedge clk) disable iff (rst)
      $fell(irst_q) |-> $past(state_q) == RBS_ST_COUNT && $past(cnt_q) == RBS_CNT_W'(RELEASE_CYCLES - 1))
      else $error("internal reset released early");
   a_delay_restart: assert property (@(posedge clk) disable iff (rst)
      !pin_s |=> cnt_q == '0 && state_q == RBS_ST_HOLD)
      else $error("delay not restarted");
   a_por_hold: assert property (@(posedge clk) disable iff (rst) por_busy |-> state_q == RBS_ST_HOLD)
      else $error("released during power-on reset");
   a_secure_forces: assert property (@(posedge clk) disable iff (rst)
      !mode_q.secured_state_bit |-> !mode_q.boot_mode_bit && !mode_q.wide_addr)
      else $error("secured flash allowed external boot");
   a_sec_stable: assert property (@(posedge clk) disable iff (rst)
      state_q == RBS_ST_RUN && $past(state_q) == RBS_ST_RUN |-> $stable(mode_q))
      else $error("mode changed outside reset");
   a_wide_lines: assert property (@(posedge clk) disable iff (rst)
      mode_q.wide_addr |-> ext_addr_lines == 5'(RBS_ADDR_WIDE))
      else $error("wide mode without 20 lines");
   a_pullup_off: assert property (@(posedge clk) disable iff (rst)
      pudr_q[RBS_PUD_RESET_POS] |-> !reset_pullup_en)
      else $error("reset pull-up still on");
endmodule : rbs_top
`default_nettype wire

//--- hw/rbs_pkg.sv
package rbs_pkg;
   // ----------------------------------------
   // Timing and address widths
   // ----------------------------------------
   localparam int unsigned RBS_CLK_HZ = 20000000;
   localparam int unsigned RBS_RELEASE_CYCLES = 64;
   localparam int unsigned RBS_CNT_W = 8;
   localparam int unsigned RBS_POR_CYCLES = 16;
   localparam int unsigned RBS_POR_W = 5;
   localparam int unsigned RBS_ADDR_NARROW = 16;
   localparam int unsigned RBS_ADDR_WIDE = 20;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] RBS_PUDR_ADDR = 4'h0;
   localparam logic [3:0] RBS_MODE_ADDR = 4'h1;
   localparam logic [3:0] RBS_STAT_ADDR = 4'h2;
   localparam int unsigned RBS_PUD_RESET_POS = 0;
   localparam int unsigned RBS_PUD_BOOT_POS = 1;
   localparam int unsigned RBS_PUD_AWIDTH_POS = 2;
   localparam logic [15:0] RBS_PUDR_RST_VAL = 16'h0000;
   localparam int unsigned RBS_MODE_BOOT_POS = 0;
   localparam int unsigned RBS_MODE_SEC_POS = 1;
   localparam int unsigned RBS_MODE_WIDE_POS = 2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      RBS_ST_HOLD = 2'b00,
      RBS_ST_COUNT = 2'b01,
      RBS_ST_RUN = 2'b10
   } rbs_state_t;

   typedef struct packed {
      logic boot_mode_bit;
      logic secured_state_bit;
      logic wide_addr;
   } rbs_mode_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } rbs_bus_t;
endpackage : rbs_pkg

//--- hw/rbs_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_sync2 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic d,
   output logic q
);
   logic meta_q;
   logic sync_q;
   // Async reset flops take constants only; line idles high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule : rbs_sync2
`default_nettype wire

//--- tb/rbs_board.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_board (
   // Board controls
   input wire logic hold_rst,
   input wire logic full_rst,
   input wire logic boot_tie,
   input wire logic aw_tie,
   // Pins
   output logic reset_pin_n,
   output logic trst_n,
   output logic boot_source_strap,
   output logic address_width_strap
);
   // test reset with full reset only
   assign trst_n = !(hold_rst && full_rst);
   assign reset_pin_n = !hold_rst;
   // straps tied hard, so pull-ups may be off
   assign boot_source_strap = boot_tie;
   assign address_width_strap = aw_tie;
endmodule : rbs_board
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   import rbs_pkg::*;
   // Short release count keeps each reset quick
   localparam int RC = 8;
   logic clk = 0, rst = 1, hold = 1, full = 1, bt = 0, aw = 0, unsec = 1;
   rbs_bus_t bus = '0;
   wire logic pin_n, boot_s, aw_s, trst;
   logic [15:0] rdata, d;
   logic rso, pu_r, pu_b, pu_a, b, a, u, w;
   rbs_mode_t mode;
   logic [4:0] lines;
   int n_errors = 0, check_count = 0, cyc = 0, n;

   rbs_board u_board (.hold_rst(hold), .full_rst(full), .boot_tie(bt), .aw_tie(aw),
      .reset_pin_n(pin_n), .trst_n(trst), .boot_source_strap(boot_s), .address_width_strap(aw_s));
   rbs_top #(.RELEASE_CYCLES(RC)) u_dut (.clk(clk), .rst(rst), .reset_pin_n(pin_n),
      .boot_source_strap(boot_s), .address_width_strap(aw_s), .flash_unsecured(unsec),
      .bus(bus), .rdata(rdata), .reset_state_output(rso), .reset_pullup_en(pu_r),
      .boot_pullup_en(pu_b), .awidth_pullup_en(pu_a), .mode(mode), .ext_addr_lines(lines));

   initial begin
      forever #25 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
      @(posedge clk);
      bus <= '{ad, wd, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] ad, output logic [15:0] rv);
      @(posedge clk);
      bus <= '{ad, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask : rd

   task automatic wait_run(output int k);
      k = 0;
      while (rso !== 1'b0 && k < 300) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_run

   task automatic pulse(output int k);
      @(posedge clk);
      hold <= 1'b1;
      repeat (RC + 12) @(negedge clk);
      `CHK(rso, 1'b1)
      `CHK(trst, ~full)
      @(posedge clk);
      hold <= 1'b0;
      wait_run(k);
   endtask : pulse

   task automatic t_release();
      pulse(n);
      `CHK(n >= RC && n <= RC + 6, 1'b1)
      @(posedge clk);
      full <= 1'b0;
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      hold <= 1'b0;
      repeat (RC - 2) @(posedge clk);
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      hold <= 1'b0;
      wait_run(n);
      `CHK(n >= RC && n <= RC + 6, 1'b1)
   endtask : t_release

   task automatic t_modes();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         bt <= i[0];
         aw <= i[1];
         unsec <= i[2];
         pulse(n);
         b = i[0];
         a = i[1];
         u = i[2];
         w = a & b & u;
         rd(RBS_MODE_ADDR, d);
         `CHK(d, {13'h0000, w, u, b & u})
         `CHK(mode, {b & u, u, w})
         `CHK(lines, w ? 5'h14 : 5'h10)
      end
      // Strap and security changes after capture must not show
      @(posedge clk);
      unsec <= 1'b0;
      bt <= 1'b0;
      aw <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(mode, 3'h7)
      `CHK(lines, 5'h14)
   endtask : t_modes

   task automatic t_regs();
      rd(RBS_PUDR_ADDR, d);
      `CHK(d, 16'h0000)
      `CHK({pu_r, pu_b, pu_a}, 3'h7)
      wr(RBS_PUDR_ADDR, 16'h0007);
      repeat (2) @(negedge clk);
      `CHK({pu_r, pu_b, pu_a}, 3'h0)
      rd(RBS_PUDR_ADDR, d);
      `CHK(d, 16'h0007)
      wr(RBS_MODE_ADDR, 16'hffff);
      rd(RBS_MODE_ADDR, d);
      `CHK(d, 16'h0007)
      rd(4'hf, d);
      `CHK(d, 16'h0000)
      wr(RBS_PUDR_ADDR, 16'h0005);
      repeat (2) @(negedge clk);
      `CHK({pu_r, pu_b, pu_a}, 3'h2)
   endtask : t_regs

   task automatic t_por();
      @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      `CHK(rso, 1'b1)
      `CHK(mode, 3'h0)
      `CHK({pu_r, pu_b, pu_a}, 3'h7)
      @(posedge clk);
      rst <= 1'b0;
      wait_run(n);
      `CHK(n >= 16 + RC && n <= 16 + RC + 10, 1'b1)
   endtask : t_por

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_release();
      t_modes();
      t_regs();
      t_por();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
